//--- hdl/fcsu_top.sv
/*
 * Flash command launch, status and error reporting unit with an APB slave.
 * Assumes an external array engine that takes one request pulse, answers
 * with a done pulse and a blank result, and a stop-mode level from the core.
 */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fcsu_regs.svh"

module fcsu_top (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	output fcsu_pkg::fcsu_array_req_type   array_req,
	input  wire logic                      array_busy,
	input  wire logic                      array_done,
	input  wire logic                      array_blank,
	input  wire logic                      stop_mode,
	output logic                           irq
);

	logic                   wr_en;
	logic                   rd_en;
	logic                   cbef_r;
	logic                   pviol_r;
	logic                   accerr_r;
	logic                   blank_r;
	logic                   divider_set_r;
	logic [7:0]             divider_r;
	logic [7:0]             protect_r;
	logic [7:0]             command_r;
	logic [2:0]             irq_mask_r;
	logic [2:0]             irq_stat_r;
	logic                   queued_r;
	logic                   exec_r;
	logic                   exec_blank_r;
	logic                   stop_meta_r;
	logic                   stop_sync_r;
	logic                   stop_prev_r;
	logic                   ccf;
	logic                   launch;
	logic                   launch_ok;
	logic                   seq_err;
	logic                   div_err;
	logic                   illegal;
	logic                   protected_hit;
	logic                   stop_err;
	logic                   move_burst;
	logic [15:0]            prot_base;
	logic [7:0]             status_rd;
	logic [31:0]            rdata_nxt;
	fcsu_pkg::fcsu_cmd_type cmd_r;
	fcsu_pkg::fcsu_cmd_type queue_r;
	fcsu_pkg::fcsu_seq_type seq_r;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pslverr = 1'b0;

	logic stat_wr;
	assign stat_wr = wr_en && (paddr == `FCSU_OFF_STATUS);
	assign launch  = stat_wr && pwdata[`FCSU_BIT_CBEF] && cbef_r;

	// Command validity checks at launch
	always_comb begin
		unique case (cmd_r.cmd)
			`FCSU_CMD_BLANK, `FCSU_CMD_PROG, `FCSU_CMD_BURST,
			`FCSU_CMD_PAGE, `FCSU_CMD_MASS: illegal = 1'b0;
			default: illegal = 1'b1;
		endcase
	end

	always_comb begin
		if (protect_r[5:3] == `FCSU_PS_FULL) begin
			prot_base = `FCSU_PROT_FULL;
		end else begin
			prot_base = 16'(`FCSU_PROT_BASE << protect_r[5:3]);
		end
	end

	always_comb begin
		protected_hit = 1'b0;
		if (cmd_r.cmd != `FCSU_CMD_BLANK) begin
			if (!protect_r[`FCSU_BIT_POPEN]) begin
				protected_hit = 1'b1;
			end else if (!protect_r[`FCSU_BIT_PDIS]) begin
				if (cmd_r.cmd == `FCSU_CMD_MASS) begin
					protected_hit = 1'b1;
				end else if (cmd_r.addr >= prot_base) begin
					protected_hit = 1'b1;
				end
			end
		end
	end

	// launch only after command write in an unbroken sequence
	assign seq_err  = (seq_r != fcsu_pkg::FCSU_SEQ_CMD);
	assign div_err  = !divider_set_r && (cmd_r.cmd != `FCSU_CMD_BLANK);
	// non-burst commands need an empty queue and idle engine
	logic busy_conflict;
	assign busy_conflict = (exec_r || queued_r) &&
		((cmd_r.cmd != `FCSU_CMD_BURST) || queued_r ||
		 (exec_r && !(cmd_r.cmd == `FCSU_CMD_BURST)));
	assign launch_ok = launch && !seq_err && !div_err && !illegal &&
		!busy_conflict && !protected_hit;

	// Stop level from the core is asynchronous to this clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_meta_r <= 1'b0;
			stop_sync_r <= 1'b0;
			stop_prev_r <= 1'b0;
		end else begin
			stop_meta_r <= stop_mode;
			stop_sync_r <= stop_meta_r;
			stop_prev_r <= stop_sync_r;
		end
	end
	assign stop_err = stop_sync_r && !stop_prev_r && (exec_r || queued_r);

	// Sequence tracker: address/data write, then command, then launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_r <= fcsu_pkg::FCSU_SEQ_IDLE;
		end else if (wr_en) begin
			unique case (paddr)
				`FCSU_OFF_ADDR, `FCSU_OFF_DATA: seq_r <= fcsu_pkg::FCSU_SEQ_DATA;
				`FCSU_OFF_COMMAND: seq_r <= (seq_r == fcsu_pkg::FCSU_SEQ_DATA) ?
					fcsu_pkg::FCSU_SEQ_CMD : fcsu_pkg::FCSU_SEQ_IDLE;
				`FCSU_OFF_IRQ_MASK, `FCSU_OFF_IRQ_STAT: seq_r <= seq_r;
				default: seq_r <= fcsu_pkg::FCSU_SEQ_IDLE;
			endcase
		end else if (rd_en && (paddr != `FCSU_OFF_STATUS) &&
			(paddr != `FCSU_OFF_IRQ_MASK) && (paddr != `FCSU_OFF_IRQ_STAT)) begin
			// Interrupt servicing may poll between steps without breaking them
			seq_r <= fcsu_pkg::FCSU_SEQ_IDLE;
		end
	end

	// Command staging registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_r <= '0;
		end else if (wr_en) begin
			if (paddr == `FCSU_OFF_ADDR) begin
				cmd_r.addr <= pwdata[15:0];
			end
			if (paddr == `FCSU_OFF_DATA) begin
				cmd_r.data <= pwdata[7:0];
			end
			if (paddr == `FCSU_OFF_COMMAND) begin
				cmd_r.cmd <= pwdata[7:0];
			end
		end
	end
	assign command_r = cmd_r.cmd;

	// Divider: any write marks it initialised; only reset un-sets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divider_r     <= 8'h00;
			divider_set_r <= 1'b0;
		end else if (wr_en && (paddr == `FCSU_OFF_DIVIDER)) begin
			divider_r     <= pwdata[7:0];
			divider_set_r <= 1'b1;
		end
	end

	// Protection: the low three bits do not exist and always read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			protect_r <= `FCSU_PROT_RESET;
		end else if (wr_en && (paddr == `FCSU_OFF_PROTECT)) begin
			protect_r <= {pwdata[7:3], 3'h0};
		end
	end

	// Command queue and execution tracking
	assign move_burst = queued_r && !exec_r;
	// A stop event in the hand-over cycle drops the command instead
	logic start_now;
	assign start_now = move_burst && !array_busy && !stop_err;

	// Launch wins over a same-cycle drop: the new command is the valid one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			queue_r  <= '0;
			queued_r <= 1'b0;
		end else if (launch_ok) begin
			queue_r  <= cmd_r;
			queued_r <= 1'b1;
		end else if (stop_err || start_now) begin
			queued_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_r       <= 1'b0;
			exec_blank_r <= 1'b0;
		end else if (start_now) begin
			exec_r       <= 1'b1;
			exec_blank_r <= (queue_r.cmd == `FCSU_CMD_BLANK);
		end else if (array_done || stop_err) begin
			exec_r <= 1'b0;
		end
	end

	// Fields stay put after the pulse, so the engine may sample them late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			array_req <= '0;
		end else begin
			array_req.start <= start_now;
			if (start_now) begin
				array_req.is_erase <= (queue_r.cmd == `FCSU_CMD_PAGE) ||
					(queue_r.cmd == `FCSU_CMD_MASS);
				array_req.is_mass  <= (queue_r.cmd == `FCSU_CMD_MASS);
				array_req.is_blank <= (queue_r.cmd == `FCSU_CMD_BLANK);
				array_req.addr     <= queue_r.addr;
				array_req.data     <= queue_r.data;
			end
		end
	end

	assign ccf = !queued_r && !exec_r;

	// Status flags; hardware set wins over a same-cycle clear, except that launch clears buffer-empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cbef_r <= 1'b1;
		end else if (launch) begin
			cbef_r <= 1'b0;
		end else if (move_burst && !array_busy) begin
			cbef_r <= 1'b1;
		end else if (!queued_r) begin
			cbef_r <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pviol_r <= 1'b0;
		end else if (launch && !seq_err && !illegal && !div_err && protected_hit) begin
			pviol_r <= 1'b1;
		end else if (stat_wr && pwdata[`FCSU_BIT_PVIOL]) begin
			pviol_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accerr_r <= 1'b0;
		end else if ((launch && (seq_err || illegal || div_err || busy_conflict)) ||
			stop_err) begin
			accerr_r <= 1'b1;
		end else if (stat_wr && pwdata[`FCSU_BIT_ACCERR]) begin
			accerr_r <= 1'b0;
		end
	end

	// A result landing in a launch cycle is kept over the launch clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_r <= 1'b0;
		end else if (exec_r && exec_blank_r && array_done) begin
			blank_r <= array_blank;
		end else if (launch_ok) begin
			blank_r <= 1'b0;
		end
	end

	always_comb begin
		status_rd = 8'h00;
		status_rd[`FCSU_BIT_CBEF]   = cbef_r;
		status_rd[`FCSU_BIT_CCF]    = ccf;
		status_rd[`FCSU_BIT_PVIOL]  = pviol_r;
		status_rd[`FCSU_BIT_ACCERR] = accerr_r;
		status_rd[`FCSU_BIT_BLANK]  = blank_r;
	end

	// Interrupt: a rising flag is an event; reading the event word clears it.
	// Edge-detected, so a flag left standing cannot defeat the clearing read.
	logic [2:0]      irq_lvl;
	logic [2:0]      irq_lvl_prev_r;
	logic            irq_stat_rd;
	wire logic [2:0] irq_stat_nxt;

	always_comb begin
		irq_lvl                          = 3'h0;
		irq_lvl[`FCSU_IRQ_DONE]   = ccf;
		irq_lvl[`FCSU_IRQ_PVIOL]  = pviol_r;
		irq_lvl[`FCSU_IRQ_ACCERR] = accerr_r;
	end
	assign irq_stat_rd = rd_en && (paddr == `FCSU_OFF_IRQ_STAT);

	// An event in the clearing cycle survives the read
	for (genvar g = 0; g < $bits(irq_lvl); g++) begin : g_irq
		assign irq_stat_nxt[g] = (irq_lvl[g] && !irq_lvl_prev_r[g]) ||
			(irq_stat_r[g] && !irq_stat_rd);
	end

	// Complete reads high out of reset; matching it avoids a false event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_lvl_prev_r <= `FCSU_IRQ_LVL_RESET;
			irq_stat_r     <= 3'h0;
		end else begin
			irq_lvl_prev_r <= irq_lvl;
			irq_stat_r     <= irq_stat_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= 3'h0;
		end else if (wr_en && (paddr == `FCSU_OFF_IRQ_MASK)) begin
			irq_mask_r <= pwdata[2:0];
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (paddr)
			`FCSU_OFF_STATUS:   rdata_nxt[7:0]  = status_rd;
			`FCSU_OFF_COMMAND:  rdata_nxt[7:0]  = command_r;
			`FCSU_OFF_ADDR:     rdata_nxt[15:0] = cmd_r.addr;
			`FCSU_OFF_DATA:     rdata_nxt[7:0]  = cmd_r.data;
			`FCSU_OFF_DIVIDER:  rdata_nxt[7:0]  = divider_r;
			`FCSU_OFF_PROTECT:  rdata_nxt[7:0]  = protect_r;
			`FCSU_OFF_IRQ_MASK: rdata_nxt[2:0]  = irq_mask_r;
			`FCSU_OFF_IRQ_STAT: rdata_nxt[2:0]  = irq_stat_r;
			default:            rdata_nxt       = 32'h0000_0000;
		endcase
	end
	assign prdata = rdata_nxt;

endmodule // fcsu_top

`default_nettype wire

//--- hdl/fcsu_regs.svh
/*
 * Register offsets, field positions, command codes and reset values for the
 * flash command and status unit; the carrier types are in fcsu_pkg.
 * Assumes an APB slave with 32-bit data; each register is one aligned word.
 */
//
// Contract
// - Status bits 3, 1, 0 read zero, ignore writes
// - Writing 1 to buffer-empty launches, clears it
// - Burst moving to array sets buffer-empty flag
// - Only burst program commands may be queued
// - Complete flag high when idle, drops on launch
// - Protected target sets violation flag, drops command
// - Violation flag clears only by writing 1
// - Broken command sequence sets access error, drops
// - Program/erase before divider written is access error
// - Stop entry during busy command is access error
// - Access error clears by 1, 0 ignored
// - Blank flag set only if array all erased
// - Blank flag clears on valid launch only
// - Codes 05 blank, 20 program, 25 burst
// - Codes 40 page erase, 41 mass erase
// - Other codes are illegal, access error
// - Protection open and disable bits select protection
`ifndef FCSU_REGS_SVH
`define FCSU_REGS_SVH

`define FCSU_OFF_STATUS   12'h000
`define FCSU_OFF_COMMAND  12'h004
`define FCSU_OFF_ADDR     12'h008
`define FCSU_OFF_DATA     12'h00C
`define FCSU_OFF_DIVIDER  12'h010
`define FCSU_OFF_PROTECT  12'h014
`define FCSU_OFF_IRQ_MASK 12'h018
`define FCSU_OFF_IRQ_STAT 12'h01C

`define FCSU_BIT_CBEF     7
`define FCSU_BIT_CCF      6
`define FCSU_BIT_PVIOL    5
`define FCSU_BIT_ACCERR   4
`define FCSU_BIT_BLANK    2

`define FCSU_CMD_BLANK    8'h05
`define FCSU_CMD_PROG     8'h20
`define FCSU_CMD_BURST    8'h25
`define FCSU_CMD_PAGE     8'h40
`define FCSU_CMD_MASS     8'h41

`define FCSU_BIT_POPEN    7
`define FCSU_BIT_PDIS     6
`define FCSU_PROT_RESET   8'h80
`define FCSU_PAGE_BYTES   512
`define FCSU_PROT_BASE    16'hFE00
`define FCSU_PROT_FULL    16'h182C
`define FCSU_PS_FULL      3'h7
`define FCSU_ERASED       8'hFF

`define FCSU_IRQ_DONE     0
`define FCSU_IRQ_PVIOL    1
`define FCSU_IRQ_ACCERR   2
`define FCSU_IRQ_LVL_RESET 3'h1

`endif

//--- hdl/fcsu_pkg.sv
/*
 * Carrier types for the flash command and status unit.
 * Assumes fcsu_regs.svh is compiled alongside for constants.
 */
package fcsu_pkg;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
		logic [7:0]  cmd;
	} fcsu_cmd_type;

	typedef struct packed {
		logic        start;
		logic        is_erase;
		logic        is_mass;
		logic        is_blank;
		logic [15:0] addr;
		logic [7:0]  data;
	} fcsu_array_req_type;

	typedef enum logic [1:0] {
		FCSU_SEQ_IDLE,
		FCSU_SEQ_DATA,
		FCSU_SEQ_CMD
	} fcsu_seq_type;

endpackage

//--- verif/fcsu_chk.sv
/* Port checker for fcsu_top.
   Bound into every fcsu_top instance; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "fcsu_regs.svh"
module fcsu_chk (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [11:0]                  paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [31:0]                  prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire fcsu_pkg::fcsu_array_req_type array_req,
	input wire logic                         array_busy,
	input wire logic                         array_done,
	input wire logic                         array_blank,
	input wire logic                         stop_mode,
	input wire logic                         irq
);
	logic [15:0] addr_r;
	logic [7:0]  data_r;
	logic [2:0]  mask_r;
	wire logic   acc = psel && penable;
	// Last target written, so each array request can be traced to it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_r <= 16'h0000;
			data_r <= 8'h00;
			mask_r <= 3'h0;
		end else if (acc && pwrite) begin
			if (paddr == `FCSU_OFF_ADDR) addr_r <= pwdata[15:0];
			if (paddr == `FCSU_OFF_DATA) data_r <= pwdata[7:0];
			if (paddr == `FCSU_OFF_IRQ_MASK) mask_r <= pwdata[2:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rsvd;
		acc && !pwrite && paddr == `FCSU_OFF_STATUS |-> prdata[3] == 1'b0 && prdata[1:0] == 2'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("status reserved bit set");
	property p_ready; psel |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("wait state inserted");
	property p_noerr; acc |-> !pslverr; endproperty
	a_noerr: assert property (p_noerr) else $error("slave error raised");
	property p_unmap; acc && !pwrite && paddr >= 12'h020 |-> prdata == 32'h00000000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_pulse; array_req.start |=> !array_req.start; endproperty
	a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
	property p_idle; array_req.start |-> !$past(array_busy); endproperty
	a_idle: assert property (p_idle) else $error("start while engine busy");
	property p_args;
		array_req.start |-> array_req.addr == addr_r && array_req.data == data_r;
	endproperty
	a_args: assert property (p_args) else $error("request target mismatch");
	property p_irq; mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq; endproperty
	a_irq: assert property (p_irq) else $error("irq while fully masked");
endmodule // fcsu_chk
bind fcsu_top fcsu_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .array_req(array_req), .array_busy(array_busy),
	.array_done(array_done), .array_blank(array_blank), .stop_mode(stop_mode), .irq(irq));
`default_nettype wire

//--- verif/fcsu_top_bench.sv
/* Self-checking bench for fcsu_top.
   Acts as APB master and as a simple array engine. */
`timescale 1ns/1ps
`default_nettype none
`include "fcsu_regs.svh"
module fcsu_top_bench;
	logic                         pclk, presetn, psel, penable, pwrite;
	logic [11:0]                  paddr;
	logic [31:0]                  pwdata, prdata, rv;
	logic                         pready, pslverr, array_busy, array_done;
	logic                         array_blank, stop_mode, irq;
	fcsu_pkg::fcsu_array_req_type array_req, last_req;
	int                           errors, compares, starts, lat, cnt;
	fcsu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .array_req(array_req), .array_busy(array_busy),
		.array_done(array_done), .array_blank(array_blank), .stop_mode(stop_mode), .irq(irq));
	always #5 pclk = ~pclk;
	// Engine stays busy lat cycles per request, so queueing can be seen
	always @(posedge pclk) begin
		array_done <= 1'b0;
		if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				array_done <= 1'b1;
				array_busy <= 1'b0;
			end
		end else if (array_req.start === 1'b1) begin
			array_busy <= 1'b1;
			cnt <= lat;
			last_req <= array_req;
			starts <= starts + 1;
		end
	end
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task complete_run;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rv = prdata;
		if (pready !== 1'b1) begin
			errors++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rs(input logic [7:0] e);
		xfer(1'b0, `FCSU_OFF_STATUS, 32'h0);
		chk("status", rv, {24'h000000, e});
	endtask
	task clr(input logic [7:0] v);
		xfer(1'b1, `FCSU_OFF_STATUS, {24'h000000, v});
	endtask
	task cs(input int n);
		chk("starts", 32'(starts), 32'(n));
	endtask
	task prot(input logic [7:0] v);
		xfer(1'b1, `FCSU_OFF_PROTECT, {24'h000000, v});
	endtask
	task cmd(input logic [7:0] c, input logic [15:0] a);
		xfer(1'b1, `FCSU_OFF_ADDR, {16'h0000, a});
		xfer(1'b1, `FCSU_OFF_DATA, 32'h0000005A);
		xfer(1'b1, `FCSU_OFF_COMMAND, {24'h000000, c});
		clr(8'h80);
	endtask
	task idle;
		int i;
		for (i = 0; i < 100; i++) begin
			xfer(1'b0, `FCSU_OFF_STATUS, 32'h0);
			if (rv[6] === 1'b1) break;
		end
		if (i == 100) begin
			errors++;
			complete_run();
		end
	endtask
	task t_reset;
		rs(8'hC0);
		xfer(1'b0, 12'h020, 32'h0);
		chk("unmapped", rv, 32'h0);
		clr(8'h0F);
		rs(8'hC0);
		cmd(8'h20, 16'h2000);
		idle();
		rs(8'hD0);
		clr(8'h00);
		rs(8'hD0);
		clr(8'h10);
		rs(8'hC0);
		cs(0);
		xfer(1'b1, `FCSU_OFF_DIVIDER, 32'h00000013);
		$display("reset and divider test ended");
	endtask
	task t_codes;
		logic [7:0] c [5] = '{8'h20, 8'h25, 8'h40, 8'h05, 8'h41};
		int i;
		prot(8'hC0);
		array_blank <= 1'b1;
		for (i = 0; i < 5; i++) begin
			cmd(c[i], 16'h2100);
			idle();
			cs(i + 1);
			chk("mass", last_req.is_mass, c[i] == 8'h41);
			chk("blank", last_req.is_blank, c[i] == 8'h05);
			chk("erase", last_req.is_erase, c[i] == 8'h40 || c[i] == 8'h41);
			chk("data", last_req.data, 8'h5A);
			rs(c[i] == 8'h05 ? 8'hC4 : 8'hC0);
		end
		array_blank <= 1'b0;
		cmd(8'h05, 16'h2100);
		idle();
		rs(8'hC0);
		$display("command code test ended");
	endtask
	task t_errs;
		xfer(1'b0, `FCSU_OFF_IRQ_STAT, 32'h0);
		xfer(1'b1, `FCSU_OFF_IRQ_MASK, 32'h00000004);
		cmd(8'h33, 16'h2100);
		idle();
		rs(8'hD0);
		chk("irq", irq, 1'b1);
		xfer(1'b0, `FCSU_OFF_IRQ_STAT, 32'h0);
		chk("irq_stat", rv[2], 1'b1);
		@(posedge pclk);
		chk("irq_off", irq, 1'b0);
		xfer(1'b1, `FCSU_OFF_IRQ_MASK, 32'h0);
		clr(8'h10);
		prot(8'h80);
		cmd(8'h20, 16'hFE10);
		idle();
		rs(8'hE0);
		xfer(1'b0, `FCSU_OFF_IRQ_STAT, 32'h0);
		chk("irq_pviol", rv[1], 1'b1);
		clr(8'h5F);
		rs(8'hE0);
		clr(8'h20);
		rs(8'hC0);
		prot(8'h00);
		cmd(8'h40, 16'h2000);
		idle();
		rs(8'hE0);
		clr(8'h20);
		xfer(1'b1, `FCSU_OFF_ADDR, 32'h00002000);
		xfer(1'b1, `FCSU_OFF_DATA, 32'h0000005A);
		prot(8'hC0);
		xfer(1'b1, `FCSU_OFF_COMMAND, 32'h00000020);
		clr(8'h80);
		idle();
		rs(8'hD0);
		clr(8'h10);
		cs(6);
		$display("error flag test ended");
	endtask
	task t_burst;
		lat = 30;
		cmd(8'h25, 16'h2000);
		rs(8'h80);
		cmd(8'h25, 16'h2001);
		rs(8'h00);
		idle();
		cs(8);
		chk("addr", last_req.addr, 16'h2001);
		cmd(8'h20, 16'h2002);
		cmd(8'h20, 16'h2003);
		idle();
		rs(8'hD0);
		cs(9);
		clr(8'h10);
		cmd(8'h20, 16'h2004);
		stop_mode <= 1'b1;
		idle();
		rs(8'hD0);
		stop_mode <= 1'b0;
		$display("burst and stop test ended");
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{array_busy, array_done, array_blank, stop_mode} = 4'h0;
		{errors, compares, starts, cnt} = '0;
		lat = 3;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_codes();
		t_errs();
		t_burst();
		complete_run();
	end
endmodule // fcsu_top_bench
`default_nettype wire
